// ==== common/clk_fanout_pkg.sv ====
// clk_fanout_pkg: constants and state codes for the clock fan-out control
// assumes one 40 MHz system clock samples every pin of the block
package clk_fanout_pkg;

    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int NUM_PAIRS   = 10;   // gated output pairs
    localparam int HOLD_PAIR   = 7;    // pair that may run free
    localparam int SYNC_STAGES = 2;    // flops ahead of any logic
    localparam int SYNC_WIDTH  = 7;    // pins passed through the syncs

    // synchroniser bit positions
    localparam int SB_REF_POS  = 6;
    localparam int SB_REF_NEG  = 5;
    localparam int SB_FB_POS   = 4;
    localparam int SB_FB_NEG   = 3;
    localparam int SB_OUT_ON   = 2;
    localparam int SB_HOLD_SEL = 1;
    localparam int SB_SUPPLY   = 0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int REF_MIN_MHZ       = 10;   // documented reference range
    localparam int REF_MAX_MHZ       = 400;
    localparam int STAB_TIME_NS      = 6000; // relock budget
    localparam int STAB_CYCLES       =
        (STAB_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int LOCK_MATCH        = 8;    // aligned samples for lock
    localparam int SLIP_LIMIT        = 8;    // misaligned samples to drop
    localparam int CNT_W             = 12;

    // ---------------------------------------------------------------
    // loop states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LOW_POWER = 2'b00,
        ST_RELOCK    = 2'b01,
        ST_LOCKED    = 2'b10,
        ST_BYPASS    = 2'b11
    } loop_state_t;

endpackage

// ==== hw/pin_sync.sv ====
// pin_sync: two-flop synchroniser for a group of asynchronous pins
// assumes the inputs are quasi-static or sampled clock levels
`timescale 1ns/1ps
module pin_sync
    import clk_fanout_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // ---------------------------------------------------------------
    // stage shift: meta feeds only the second flop
    // ---------------------------------------------------------------
    always_comb begin
        next_st.meta   = i_async;
        next_st.stable = st.meta;
    end

    // register the copy
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stable;

endmodule

// ==== hw/clk_fanout.sv ====
// clk_fanout: sampled model of a zero-delay clock fan-out buffer control
// assumes all pins are asynchronous to i_sys_clk and pass two flops;
// clock pins are seen as sampled levels, so the model reproduces gating,
// mode and lock behaviour rather than picosecond timing
`timescale 1ns/1ps
module clk_fanout
    import clk_fanout_pkg::*;
#(
    parameter int PAIRS       = NUM_PAIRS,
    parameter int STAB_COUNT  = STAB_CYCLES,
    parameter int MATCH_COUNT = LOCK_MATCH,
    parameter int SLIP_COUNT  = SLIP_LIMIT
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_ref_in_pos,
    input  wire logic             i_ref_in_neg,
    input  wire logic             i_feedback_in_pos,
    input  wire logic             i_feedback_in_neg,
    input  wire logic             i_outputs_on,
    input  wire logic             i_pair7_hold_select,
    input  wire logic             i_pll_supply_tap,
    output logic      [PAIRS-1:0] o_drive_pair_pos,
    output logic      [PAIRS-1:0] o_drive_pair_neg,
    output logic      [PAIRS-1:0] o_drive_pair_oe,
    output logic                  o_feedback_out_pos,
    output logic                  o_feedback_out_neg,
    output logic                  o_feedback_out_oe,
    output logic                  o_pll_on,
    output logic                  o_pll_locked,
    output logic                  o_low_power,
    output logic                  o_lock_timeout
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        loop_state_t      mode;
        logic [1:0]       strap_age;
        logic             hold_sel;
        logic [CNT_W-1:0] stab_cnt;
        logic [CNT_W-1:0] match_cnt;
        logic [CNT_W-1:0] slip_cnt;
        logic             timeout;
        logic [PAIRS-1:0] pair_pos;
        logic [PAIRS-1:0] pair_neg;
        logic [PAIRS-1:0] pair_oe;
        logic             fb_pos;
        logic             fb_neg;
        logic             fb_oe;
    } fanout_state_t;

    fanout_state_t st;
    fanout_state_t next_st;

    logic [SYNC_WIDTH-1:0] pins;
    logic [PAIRS-1:0]      pair_en;
    logic                  ref_pos;
    logic                  ref_neg;
    logic                  fb_pos_in;
    logic                  fb_neg_in;
    logic                  out_on;
    logic                  supply_up;
    logic                  both_low;
    logic                  both_high;
    logic                  awake;
    logic                  aligned;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    pin_sync #(
        .WIDTH (SYNC_WIDTH)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_async   ({i_ref_in_pos, i_ref_in_neg, i_feedback_in_pos,
                     i_feedback_in_neg, i_outputs_on,
                     i_pair7_hold_select, i_pll_supply_tap}),
        .o_sync    (pins)
    );

    // decoded pin levels
    // any reference rate in range reaches here as sampled levels
    assign ref_pos   = pins[SB_REF_POS];
    assign ref_neg   = pins[SB_REF_NEG];
    assign fb_pos_in = pins[SB_FB_POS];
    assign fb_neg_in = pins[SB_FB_NEG];
    assign out_on    = pins[SB_OUT_ON];
    assign supply_up = pins[SB_SUPPLY];
    assign both_low  = !ref_pos && !ref_neg;
    assign both_high = ref_pos && ref_neg;
    assign awake     = (st.mode != ST_LOW_POWER) && !both_low;
    // feedback phase matches the reference sample
    assign aligned   = (fb_pos_in == ref_pos) && (fb_neg_in == ref_neg);

    // ---------------------------------------------------------------
    // per-pair gating
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PAIRS; gi++) begin : g_gate
            if (gi == HOLD_PAIR) begin : g_hold
                // free running when strap low, enable ignored
                assign pair_en[gi] = awake &&
                    (out_on || !st.hold_sel);
            end else begin : g_plain
                assign pair_en[gi] = awake && out_on;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;

        // strap followed until it has crossed both synchroniser flops
        // after reset release, then held; the flops read zero in reset
        if (st.strap_age != 2'(SYNC_STAGES + 1)) begin
            next_st.hold_sel  = pins[SB_HOLD_SEL];
            next_st.strap_age = st.strap_age + 2'h1;
        end

        // loop mode sequencing
        if (both_low) begin
            next_st.mode      = ST_LOW_POWER;
            next_st.stab_cnt  = '0;
            next_st.match_cnt = '0;
            next_st.slip_cnt  = '0;
        end else begin
            case (st.mode)
                ST_LOW_POWER: begin
                    // wake only on a real differential level
                    if (!both_high) begin
                        next_st.mode = supply_up ? ST_RELOCK
                                                 : ST_BYPASS;
                    end
                    next_st.stab_cnt  = '0;
                    next_st.match_cnt = '0;
                end
                ST_RELOCK: begin
                    if (!supply_up) begin
                        next_st.mode = ST_BYPASS;
                    end else begin
                        if (st.stab_cnt != CNT_W'(STAB_COUNT)) begin
                            next_st.stab_cnt = st.stab_cnt + 1'b1;
                        end else if (!st.timeout) begin
                            next_st.timeout = 1'b1;
                        end
                        if (aligned) begin
                            next_st.match_cnt = st.match_cnt + 1'b1;
                            if (st.match_cnt ==
                                CNT_W'(MATCH_COUNT - 1)) begin
                                next_st.mode     = ST_LOCKED;
                                next_st.slip_cnt = '0;
                            end
                        end else begin
                            next_st.match_cnt = '0;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (!supply_up) begin
                        next_st.mode = ST_BYPASS;
                    end else if (aligned) begin
                        // short slips of a modulated reference are
                        // absorbed without dropping lock
                        next_st.slip_cnt = '0;
                    end else if (st.slip_cnt ==
                                 CNT_W'(SLIP_COUNT - 1)) begin
                        next_st.mode      = ST_RELOCK;
                        next_st.stab_cnt  = '0;
                        next_st.match_cnt = '0;
                    end else begin
                        next_st.slip_cnt = st.slip_cnt + 1'b1;
                    end
                end
                ST_BYPASS: begin
                    // supply restored: bring the loop back up
                    if (supply_up) begin
                        next_st.mode      = ST_RELOCK;
                        next_st.stab_cnt  = '0;
                        next_st.match_cnt = '0;
                    end
                end
                default: begin
                    next_st.mode = ST_LOW_POWER;
                end
            endcase
        end

        // output drive; reserved input combination holds last drive
        if (!both_high) begin
            next_st.pair_oe  = pair_en;
            next_st.pair_pos = pair_en & {PAIRS{ref_pos}};
            next_st.pair_neg = pair_en & {PAIRS{ref_neg}};
            // feedback ignores the enable, only low power stops it
            next_st.fb_oe  = awake;
            next_st.fb_pos = awake && ref_pos;
            next_st.fb_neg = awake && ref_neg;
        end
    end

    // register the copy
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    assign o_drive_pair_pos   = st.pair_pos;
    assign o_drive_pair_neg   = st.pair_neg;
    assign o_drive_pair_oe    = st.pair_oe;
    assign o_feedback_out_pos = st.fb_pos;
    assign o_feedback_out_neg = st.fb_neg;
    assign o_feedback_out_oe  = st.fb_oe;
    assign o_pll_on           = (st.mode == ST_RELOCK) ||
                                (st.mode == ST_LOCKED);
    assign o_pll_locked       = (st.mode == ST_LOCKED);
    assign o_low_power        = (st.mode == ST_LOW_POWER);
    assign o_lock_timeout     = st.timeout;

endmodule

// ==== bench/clk_fanout_asserts.sv ====
// clk_fanout_asserts: port-level checker for the clock fan-out control
// assumes a complementary reference, never both halves high
`timescale 1ns/1ps
module clk_fanout_asserts
    import clk_fanout_pkg::*;
#(
    parameter int PAIRS = NUM_PAIRS
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_ref_in_pos,
    input  wire logic             i_ref_in_neg,
    input  wire logic             i_feedback_in_pos,
    input  wire logic             i_feedback_in_neg,
    input  wire logic             i_outputs_on,
    input  wire logic             i_pair7_hold_select,
    input  wire logic             i_pll_supply_tap,
    input  wire logic [PAIRS-1:0] o_drive_pair_pos,
    input  wire logic [PAIRS-1:0] o_drive_pair_neg,
    input  wire logic [PAIRS-1:0] o_drive_pair_oe,
    input  wire logic             o_feedback_out_pos,
    input  wire logic             o_feedback_out_neg,
    input  wire logic             o_feedback_out_oe,
    input  wire logic             o_pll_on,
    input  wire logic             o_pll_locked,
    input  wire logic             o_low_power,
    input  wire logic             o_lock_timeout
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    localparam int LOCK_MAX = 24;
    logic [2:0]       settle;
    logic [PAIRS-1:0] mask7;
    logic             ok;
    assign mask7 = PAIRS'(1) << HOLD_PAIR;
    assign ok    = (settle == 3'h4);
    // edges since reset, so three-deep history is post-reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst)
            settle <= 3'h0;
        else if (!ok)
            settle <= settle + 3'h1;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    sequence s_wake;
        $fell(o_low_power) ##0 o_pll_on;
    endsequence
    sequence s_slip;
        o_pll_locked ##0 (i_feedback_in_pos != i_ref_in_pos) [*8];
    endsequence
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_pos_follow: assert property (ok |->
        o_drive_pair_pos ==
        (o_drive_pair_oe & {PAIRS{$past(i_ref_in_pos, 3)}}))
        else $error("pair level not the gated reference");
    a_neg_follow: assert property (ok |->
        o_drive_pair_neg ==
        (o_drive_pair_oe & {PAIRS{$past(i_ref_in_neg, 3)}}))
        else $error("pair complement not the gated reference");
    a_fb_follow: assert property (ok |->
        o_feedback_out_neg == (o_feedback_out_oe & $past(i_ref_in_neg, 3)))
        else $error("feedback level not the reference");
    a_fb_pos_follow: assert property (ok |->
        o_feedback_out_pos == (o_feedback_out_oe & $past(i_ref_in_pos, 3)))
        else $error("feedback true half not the reference");
    a_gate_off: assert property (ok &&
        !$past(i_outputs_on, 3) |-> (o_drive_pair_oe & ~mask7) == '0)
        else $error("pair driven while disabled");
    // on wake the mode flops lead the drive flops by one cycle
    a_fb_runs: assert property (ok &&
        !o_low_power && !$past(o_low_power) &&
        $past(i_ref_in_pos | i_ref_in_neg, 3) |-> o_feedback_out_oe)
        else $error("feedback stopped while awake");
    a_pair7_hold: assert property (ok &&
        !o_low_power && !$past(o_low_power) &&
        $past(i_ref_in_pos | i_ref_in_neg, 3) |->
        o_drive_pair_oe[HOLD_PAIR] ==
        ($past(i_outputs_on, 3) | !$past(i_pair7_hold_select, 3)))
        else $error("pair seven gating wrong");
    a_bypass_off: assert property (ok &&
        !$past(i_pll_supply_tap, 3) |-> !o_pll_on && !o_pll_locked)
        else $error("loop running in bypass");
    a_low_power: assert property (ok &&
        !$past(i_ref_in_pos | i_ref_in_neg, 3) |-> o_low_power &&
        o_drive_pair_oe == '0 && !o_feedback_out_oe && !o_pll_on)
        else $error("low power not entered");
    a_wake_lock: assert property (s_wake |->
        ##[1:LOCK_MAX] o_pll_locked)
        else $error("no lock after wake");
    a_timeout_hold: assert property (o_lock_timeout |=>
        o_lock_timeout)
        else $error("timeout flag dropped");
    a_slip_drop: assert property (s_slip |->
        ##[1:6] !o_pll_locked)
        else $error("lock kept while misaligned");
endmodule

bind clk_fanout clk_fanout_asserts #(.PAIRS(PAIRS)) u_chk (.*);

// ==== bench/clk_src_model.sv ====
// clk_src_model: reference source plus the board feedback trace
// assumes sampling by the system clock; the pair flips each edge
`timescale 1ns/1ps
module clk_src_model (
    input  wire logic i_sys_clk,
    input  wire logic i_run,
    input  wire logic i_skew,
    output logic      o_ref_pos,
    output logic      o_ref_neg,
    output logic      o_fb_pos,
    output logic      o_fb_neg
);
    logic phase = 1'b0;
    // complementary pair; pulldowns take both low when stopped
    always @(posedge i_sys_clk) begin
        phase     <= ~phase;
        o_ref_pos <= i_run & ~phase;
        o_ref_neg <= i_run & phase;
        o_fb_pos  <= i_run & (~phase ^ i_skew);
        o_fb_neg  <= i_run & (phase ^ i_skew);
    end
endmodule

// ==== bench/pll_clock_fanout_gating_tb.sv ====
// pll_clock_fanout_gating_tb: self-checking bench for clk_fanout
// assumes clk_src_model as source and the bound checker beside it
`timescale 1ns/1ps
module pll_clock_fanout_gating_tb;
    import clk_fanout_pkg::*;
    logic i_sys_clk = 1'b0, i_srst = 1'b1, i_outputs_on = 1'b0;
    logic i_pair7_hold_select = 1'b0, i_pll_supply_tap = 1'b1;
    logic i_ref_in_pos, i_ref_in_neg, i_feedback_in_pos, i_feedback_in_neg;
    logic run = 1'b0, skew = 1'b0;
    logic [9:0] o_drive_pair_pos, o_drive_pair_neg, o_drive_pair_oe;
    logic o_feedback_out_pos, o_feedback_out_neg, o_feedback_out_oe;
    logic o_pll_on, o_pll_locked, o_low_power, o_lock_timeout;
    int bad_count = 0, n_tests = 0;
    // rows: strap, enable, supply, expected pair enables
    logic [12:0] rows [6] = '{{3'b011, 10'h3ff}, {3'b001, 10'h080},
        {3'b101, 10'h000}, {3'b111, 10'h3ff}, {3'b000, 10'h080},
        {3'b100, 10'h000}};
    // ---------------------------------------------------------------
    // clock, source and design
    // ---------------------------------------------------------------
    always #12.5 i_sys_clk = ~i_sys_clk;
    clk_src_model src (.i_sys_clk(i_sys_clk), .i_run(run), .i_skew(skew),
        .o_ref_pos(i_ref_in_pos), .o_ref_neg(i_ref_in_neg),
        .o_fb_pos(i_feedback_in_pos), .o_fb_neg(i_feedback_in_neg));
    clk_fanout #(.STAB_COUNT(16)) dut (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // bounded wait for the lock flag to reach a level
    task automatic wait_lock(input logic want);
        for (int k = 0; k < 40 && o_pll_locked !== want; k++) cyc(1);
    endtask
    task automatic do_reset(input logic strap);
        @(posedge i_sys_clk);
        i_srst <= 1'b1;
        run <= 1'b0;
        skew <= 1'b0;
        i_pair7_hold_select <= strap;
        cyc(3);
        check({o_drive_pair_oe, o_pll_on, o_low_power}, 16'h0001);
        @(posedge i_sys_clk);
        i_srst <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
    // ---------------------------------------------------------------
    // gating table, then mode changes
    // ---------------------------------------------------------------
    initial begin
        foreach (rows[r]) begin
            do_reset(rows[r][12]);
            @(posedge i_sys_clk);
            i_outputs_on <= rows[r][11];
            i_pll_supply_tap <= rows[r][10];
            run <= 1'b1;
            cyc(6);
            wait_lock(rows[r][10]);
            check(o_drive_pair_oe, rows[r][9:0]);
            check(o_feedback_out_oe, 1'b1);
            check({o_pll_on, o_pll_locked}, {2{rows[r][10]}});
        end
        do_reset(1'b0);
        @(posedge i_sys_clk);
        {i_outputs_on, i_pll_supply_tap, run} <= 3'b111;
        cyc(6);
        wait_lock(1'b1);
        @(posedge i_sys_clk);
        i_pll_supply_tap <= 1'b0;
        cyc(4);
        check({o_pll_on, o_pll_locked, o_drive_pair_oe}, 12'h3ff);
        @(posedge i_sys_clk);
        i_pll_supply_tap <= 1'b1;
        wait_lock(1'b1);
        check(o_pll_locked, 1'b1);
        @(posedge i_sys_clk);
        run <= 1'b0;
        cyc(4);
        check({o_low_power, o_feedback_out_oe, o_pll_on}, 3'h4);
        check(o_drive_pair_oe | o_drive_pair_pos, 16'h0000);
        check(o_drive_pair_neg, 16'h0000);
        @(posedge i_sys_clk);
        run <= 1'b1;
        cyc(4);
        check({o_low_power, o_pll_on}, 16'h0001);
        wait_lock(1'b1);
        check({o_pll_locked, o_lock_timeout}, 16'h0002);
        // a feedback slip shorter than the drop limit keeps lock
        @(posedge i_sys_clk);
        skew <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        skew <= 1'b0;
        cyc(12);
        check(o_pll_locked, 1'b1);
        @(posedge i_sys_clk);
        skew <= 1'b1;
        wait_lock(1'b0);
        check(o_pll_locked, 1'b0);
        cyc(20);
        check(o_lock_timeout, 1'b1);
        @(posedge i_sys_clk);
        skew <= 1'b0;
        wait_lock(1'b1);
        check({o_pll_locked, o_lock_timeout}, 16'h0003);
        final_report();
    end
endmodule
